//--- src/lstrx_pkg.sv
// line-side timing and receive input: shared constants
// assumes a 32-bit avalon-mm slave with byte addressing
package lstrx_pkg;

  // register byte offsets
  localparam logic [3:0] LSTRX_OFS_MODE   = 4'h0;
  localparam logic [3:0] LSTRX_OFS_RXCFG  = 4'h4;
  localparam logic [3:0] LSTRX_OFS_STATUS = 4'h8;

  // reset values
  localparam logic [7:0] LSTRX_MODE_RST  = 8'h00;
  localparam logic [1:0] LSTRX_RXCFG_RST = 2'h0;

  // mode field: local time when bit 1 set or low bits read 01
  localparam int         LSTRX_MODE_B0    = 0;
  localparam int         LSTRX_MODE_B1    = 1;

  // receive configuration fields
  localparam int LSTRX_RXCFG_BIPOLAR = 0;
  localparam int LSTRX_RXCFG_FALLING = 1;

  // status fields
  localparam int LSTRX_ST_LOCAL = 0;
  localparam int LSTRX_ST_BIPOL = 1;
  localparam int LSTRX_ST_POS   = 2;
  localparam int LSTRX_ST_NEG   = 3;
  localparam int LSTRX_ST_TXBIT = 4;

  // nominal reference rates the terminal side should supply, in khz
  localparam int LSTRX_E3_REF_KHZ  = 34368;
  localparam int LSTRX_DS3_REF_KHZ = 44736;

  // positions inside the synchronised input vector
  localparam int LSTRX_IN_TXCLK = 0;
  localparam int LSTRX_IN_RXCLK = 1;
  localparam int LSTRX_IN_TX_SERIAL_PAYLOAD_IN = 2;
  localparam int LSTRX_IN_RX_POSITIVE_RAIL = 3;
  localparam int LSTRX_IN_RX_NEGATIVE_RAIL = 4;
  localparam int LSTRX_IN_W     = 5;

endpackage

//--- src/lstrx_sync.sv
// two-flop synchroniser with edge detection for a vector of pins
// assumes all inputs are asynchronous to clk and slow against it
`timescale 1ns/1ps
module lstrx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_q,
  output logic      [W-1:0] rise_q,
  output logic      [W-1:0] fall_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // first stage feeds only the second; edges use stages two and three
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // level and edge outputs stay aligned with each other
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_q <= '0;
      rise_q  <= '0;
      fall_q  <= '0;
    end else begin
      level_q <= sync_q;
      rise_q  <= sync_q & ~prev_q;
      fall_q  <= ~sync_q & prev_q;
    end
  end

endmodule

//--- src/lstrx_top.sv
// line-side timing selection and receive rail capture, one channel
// assumes avalon-mm master on clk; link clocks are slow pins sampled here
//
// How it works
// - local time: transmit timing follows the transmit reference clock
// - local time: payload bit sampled at each reference clock rise
// - local time when mode low bits are 01 or bit 1 set
// - receive rails captured using the recovered line clock
// - receive logic is timed by the recovered line clock
// - transmit may instead be timed by the recovered line clock
// - unipolar: positive rail is data, latched on a chosen edge
// - bipolar: positive rail high marks a positive line pulse
// - unipolar ignores negative rail; bipolar high marks negative pulse
`timescale 1ns/1ps
module lstrx_top
  import lstrx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        tx_reference_clock_in,
  input  wire logic        rx_recovered_line_clock,
  input  wire logic        tx_serial_payload_in,
  input  wire logic        rx_positive_rail,
  input  wire logic        rx_negative_rail,
  output logic             tx_timing_tick,
  output logic             tx_payload_bit,
  output logic             rx_data_valid,
  output logic             rx_pos_data,
  output logic             rx_neg_data,
  output logic             tx_local_time
);

  // local-time decode, used by the timing select and the assertions
  function automatic logic is_local(input logic [7:0] mode);
    return mode[LSTRX_MODE_B1] |
           (mode[LSTRX_MODE_B0] & ~mode[LSTRX_MODE_B1]);
  endfunction

  logic [LSTRX_IN_W-1:0] pin_lvl;
  logic [LSTRX_IN_W-1:0] pin_rise;
  logic [LSTRX_IN_W-1:0] pin_fall;
  logic [7:0]            mode_q;
  logic [1:0]            rxcfg_q;
  logic                  wait_q;
  logic [31:0]           rdata_q;
  logic                  local_q;
  logic                  tick_q;
  logic                  txbit_q;
  logic                  rxv_q;
  logic                  pos_q;
  logic                  neg_q;
  logic                  req;
  logic                  ack;
  logic                  rx_edge;

  // every pin, clocks included, crosses through two flops first
  lstrx_sync #(
    .W (LSTRX_IN_W)
  ) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({rx_negative_rail, rx_positive_rail, tx_serial_payload_in,
                rx_recovered_line_clock, tx_reference_clock_in}),
    .level_q  (pin_lvl),
    .rise_q   (pin_rise),
    .fall_q   (pin_fall)
  );

  assign req = avs_read | avs_write;
  assign ack = req & ~wait_q;

  // one wait cycle per access, then a single-cycle acknowledge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // register writes land on the edge the master sees waitrequest low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q  <= LSTRX_MODE_RST;
      rxcfg_q <= LSTRX_RXCFG_RST;
    end else if (ack && avs_write && avs_byteenable[0]) begin
      if (avs_address == LSTRX_OFS_MODE) begin
        mode_q <= avs_writedata[7:0];
      end
      if (avs_address == LSTRX_OFS_RXCFG) begin
        rxcfg_q <= avs_writedata[1:0];
      end
    end
  end

  // read data prepared while waitrequest is still high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else if (req && wait_q) begin
      rdata_q <= 32'h0000_0000;
      unique case (avs_address)
        LSTRX_OFS_MODE:   rdata_q[7:0] <= mode_q;
        LSTRX_OFS_RXCFG:  rdata_q[1:0] <= rxcfg_q;
        LSTRX_OFS_STATUS: begin
          rdata_q[LSTRX_ST_LOCAL] <= local_q;
          rdata_q[LSTRX_ST_BIPOL] <= rxcfg_q[LSTRX_RXCFG_BIPOLAR];
          rdata_q[LSTRX_ST_POS]   <= pos_q;
          rdata_q[LSTRX_ST_NEG]   <= neg_q;
          rdata_q[LSTRX_ST_TXBIT] <= txbit_q;
        end
        default:          rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // timing source: reference clock in local time, else loop timing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      local_q <= 1'b0;
    end else begin
      local_q <= is_local(mode_q);
    end
  end

  // transmit tick and payload sample on the chosen clock's rising edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q  <= 1'b0;
      txbit_q <= 1'b0;
    end else begin
      tick_q <= local_q ? pin_rise[LSTRX_IN_TXCLK]
                        : pin_rise[LSTRX_IN_RXCLK];
      if (local_q ? pin_rise[LSTRX_IN_TXCLK] : pin_rise[LSTRX_IN_RXCLK]) begin
        txbit_q <= pin_lvl[LSTRX_IN_TX_SERIAL_PAYLOAD_IN];
      end
    end
  end

  // bipolar uses the rising edge; unipolar edge is software selected
  assign rx_edge = (rxcfg_q[LSTRX_RXCFG_BIPOLAR] ||
                    !rxcfg_q[LSTRX_RXCFG_FALLING])
                   ? pin_rise[LSTRX_IN_RXCLK]
                   : pin_fall[LSTRX_IN_RXCLK];

  // rail capture timed only by the recovered clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxv_q <= 1'b0;
      pos_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      rxv_q <= rx_edge;
      if (rx_edge) begin
        pos_q <= pin_lvl[LSTRX_IN_RX_POSITIVE_RAIL];
        // unipolar leaves the negative rail unread
        neg_q <= rxcfg_q[LSTRX_RXCFG_BIPOLAR] &
                 pin_lvl[LSTRX_IN_RX_NEGATIVE_RAIL];
      end
    end
  end

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign tx_timing_tick  = tick_q;
  assign tx_payload_bit  = txbit_q;
  assign tx_local_time   = local_q;
  assign rx_data_valid   = rxv_q;
  assign rx_pos_data     = pos_q;
  assign rx_neg_data     = neg_q;

  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);

  local_decode_a: assert property (
    ##1 local_q == is_local($past(mode_q)))
    else $error("local-time flag does not follow mode register");

  tx_ref_src_a: assert property (
    local_q && pin_rise[LSTRX_IN_TXCLK] |=> tick_q)
    else $error("reference clock rise gave no transmit tick");

  loop_src_a: assert property (
    !local_q && pin_rise[LSTRX_IN_RXCLK] |=> tick_q)
    else $error("loop timing missed a recovered clock rise");

  tick_cause_a: assert property (
    tick_q |-> $past(local_q ? pin_rise[LSTRX_IN_TXCLK]
                             : pin_rise[LSTRX_IN_RXCLK]))
    else $error("transmit tick without a selected clock rise");

  tx_sample_a: assert property (
    tick_q |-> txbit_q == $past(pin_lvl[LSTRX_IN_TX_SERIAL_PAYLOAD_IN]))
    else $error("payload bit not sampled at the tick");

  rx_pos_cap_a: assert property (
    rxv_q |-> pos_q == $past(pin_lvl[LSTRX_IN_RX_POSITIVE_RAIL]))
    else $error("positive rail not latched on receive edge");

  rx_edge_sel_a: assert property (
    rxv_q && !rxcfg_q[LSTRX_RXCFG_BIPOLAR] && $stable(rxcfg_q) |->
    $past(rxcfg_q[LSTRX_RXCFG_FALLING] ? pin_fall[LSTRX_IN_RXCLK]
                                       : pin_rise[LSTRX_IN_RXCLK]))
    else $error("unipolar capture on the wrong clock edge");

  rx_neg_uni_a: assert property (
    rxv_q && !$past(rxcfg_q[LSTRX_RXCFG_BIPOLAR]) |-> !neg_q)
    else $error("negative rail used in unipolar mode");

  rx_bipol_a: assert property (
    rxv_q && $past(rxcfg_q[LSTRX_RXCFG_BIPOLAR]) |->
    neg_q == $past(pin_lvl[LSTRX_IN_RX_NEGATIVE_RAIL]) &&
    $past(pin_rise[LSTRX_IN_RXCLK]))
    else $error("bipolar rails not latched on recovered rise");

  bus_wait_a: assert property (
    req && wait_q |=> !wait_q ##1 wait_q)
    else $error("waitrequest not low for exactly one cycle");

endmodule

//--- sim/lstrx_liu_model.sv
// line interface unit model: recovered clock and receive rails
// assumes the bench seeds the random source once
`timescale 1ns/1ps
module lstrx_liu_model (
  input  wire logic run,
  input  wire logic late,
  output logic      line_clk,
  output logic      pos,
  output logic      neg
);
  // 160 ns clock, phase unrelated to clk; stands low while not run
  initial begin
    line_clk = 1'b0;
    #7;
    forever #80 line_clk = run & ~line_clk;
  end
  // rails move half a period away from the capture edge, never both high
  initial {pos, neg} = 2'b01;
  always @(line_clk) if (line_clk === late) {pos, neg} = 2'($urandom_range(2));
endmodule

//--- sim/lstrx_top_test.sv
// self-checking bench for line-side timing and receive capture
// assumes the register bus of lstrx_top answers within 20 clk cycles, whatever its number of wait cycles
`timescale 1ns/1ps
module lstrx_top_test;
  import lstrx_pkg::*;
  logic        clk, rst_b, rd, wr, ref_clk, tx_ser, run, ref_en, lprev;
  logic [3:0]  adr, be;
  logic [31:0] wd, rdat, q;
  logic        wait_r, tick, tbit, rv, rp, rn, loc, lclk, pos, neg;
  logic        e_loc, e_bip, e_fall, tl;
  logic [1:0]  div, er;
  logic [7:0]  v;
  logic        tq[$];
  logic [1:0]  rq[$];
  int          n_fail, check_count, cyc, nt;

  lstrx_top u_dut (.clk(clk), .rst_b(rst_b), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .tx_reference_clock_in(ref_clk), .rx_recovered_line_clock(lclk),
    .tx_serial_payload_in(tx_ser), .rx_positive_rail(pos),
    .rx_negative_rail(neg), .tx_timing_tick(tick), .tx_payload_bit(tbit),
    .rx_data_valid(rv), .rx_pos_data(rp), .rx_neg_data(rn),
    .tx_local_time(loc));
  lstrx_liu_model u_liu (.run(run), .late(e_fall & ~e_bip), .line_clk(lclk),
    .pos(pos), .neg(neg));

  // system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // reference clock of 8 clk; payload moves on the unused edge
  always @(posedge clk) begin
    cyc <= cyc + 1;
    lprev <= lclk;
    div <= div + 2'h1;
    if (div == 2'h3) ref_clk <= ref_en & ~ref_clk;
    if (e_loc ? (div == 2'h3 && ref_clk) : (lprev && !lclk))
      tx_ser <= 1'($urandom_range(1));
    if (cyc == 5000) begin
      n_fail++;
      finish_test();
    end
  end
  // expected samples are taken at the edges that should cause them
  always @(posedge ref_clk) if (e_loc) tq.push_back(tx_ser);
  always @(posedge lclk) if (!e_loc) tq.push_back(tx_ser);
  // capture edge is the one opposite to where the model moves the rails
  always @(lclk) begin
    if (lclk === ~(e_fall & ~e_bip)) rq.push_back({pos, e_bip & neg});
  end
  // each output pulse is matched against the oldest expected sample
  always @(posedge clk) begin
    if (tick === 1'b1) begin
      nt++;
      tl = tq.size() ? tq.pop_front() : 1'bx;
      chk("tx_bit", tl, tbit);
    end
    if (rv === 1'b1) begin
      er = rq.size() ? rq.pop_front() : 2'bxx;
      chk("rx_pos", er[1], rp);
      chk("rx_neg", er[0], rn);
    end
  end

  // local time when the low bits read 01 or bit 1 is set
  function automatic logic exp_local(input logic [7:0] m);
    return (m[1:0] == 2'h1) | m[1];
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon access; no cycle count assumed, bounded wait
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (wait_r !== 1'b0 && n < 20);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      finish_test();
    end
  endtask
  // configure with both clocks stopped, then run 12 line periods
  task automatic traffic(input logic [7:0] m, input logic [1:0] c);
    run <= 1'b0;
    ref_en <= 1'b0;
    repeat (12) @(posedge clk);
    bus(1'b1, LSTRX_OFS_MODE, {24'h0, m}, 4'hF);
    bus(1'b1, LSTRX_OFS_RXCFG, {30'h0, c}, 4'hF);
    e_loc = exp_local(m);
    e_bip = c[0];
    e_fall = c[1];
    repeat (12) @(posedge clk);
    tq.delete();
    rq.delete();
    nt = 0;
    run <= 1'b1;
    ref_en <= 1'b1;
    repeat (96) @(posedge clk);
    run <= 1'b0;
    ref_en <= 1'b0;
    repeat (12) @(posedge clk);
    chk("tx_left", 0, 32'(tq.size()));
    chk("rx_left", 0, 32'(rq.size()));
    chk("ticks", 1, 32'(nt > 9));
    // status holds the last captured rails and the last payload bit
    bus(1'b0, LSTRX_OFS_STATUS, 32'h0, 4'hF);
    chk("status", {27'h0, tl, er[0], er[1], e_bip, e_loc}, q);
    bus(1'b0, LSTRX_OFS_RXCFG, 32'h0, 4'hF);
    chk("rxcfg", {30'h0, c}, q);
    $display("test traffic mode %h cfg %h done", m, c);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // main sequence
  initial begin
    {rst_b, rd, wr, ref_clk, tx_ser, run, ref_en, lprev} = 8'h00;
    {adr, be, wd, div, v} = 50'h0;
    {e_loc, e_bip, e_fall} = 3'h0;
    {n_fail, check_count, cyc, nt} = '0;
    void'($urandom(6));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    bus(1'b0, LSTRX_OFS_MODE, 32'h0, 4'hF);
    chk("mode_rst", {24'h0, LSTRX_MODE_RST}, q);
    chk("local_rst", 0, loc);
    for (int i = 0; i < 8; i++) begin
      v = i < 4 ? 8'(i) : 8'($urandom_range(255));
      bus(1'b1, LSTRX_OFS_MODE, {24'h0, v}, 4'hF);
      bus(1'b0, LSTRX_OFS_MODE, 32'h0, 4'hF);
      chk("mode", {24'h0, v}, q & 32'hFF);
      chk("local", exp_local(v), loc);
    end
    bus(1'b1, 4'hC, 32'hFF, 4'hF);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    chk("unmapped", 0, q);
    bus(1'b1, LSTRX_OFS_MODE, 32'h0, 4'hF);
    bus(1'b1, LSTRX_OFS_MODE, 32'h3, 4'h0);
    bus(1'b0, LSTRX_OFS_MODE, 32'h0, 4'hF);
    chk("mode_be", 0, q & 32'hFF);
    $display("test registers done");
    traffic(8'h01, 2'h0);
    traffic(8'h00, 2'h2);
    traffic(8'h02, 2'h1);
    traffic(8'h00, 2'h3);
    finish_test();
  end
endmodule
